// ===== include/lmac_pkg.sv
/*
 * Shared constants of the logger mission/alarm control register bank:
 * register indices, field positions, fixed read bits and log layout.
 * Assumes a 32-bit Avalon-MM bus whose byte address is four times the index.
 */
package lmac_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int LOG_ADDR_W = 16;

	// register indices; byte address = index * 4
	localparam logic [9:0] IDX_LOW_THR = 10'h208;
	localparam logic [9:0] IDX_HIGH_THR = 10'h209;
	localparam logic [9:0] IDX_SENSOR_EN = 10'h210;
	localparam logic [9:0] IDX_CLOCK_CTRL = 10'h212;
	localparam logic [9:0] IDX_MISSION_SETUP = 10'h213;
	localparam logic [9:0] IDX_ALARM_FLAGS = 10'h214;
	localparam logic [9:0] IDX_MISSION_STATE = 10'h215;

	// sensor_alarm_enable fields
	localparam int BIT_LOW_EN = 0;
	localparam int BIT_HIGH_EN = 1;
	// clock_control fields
	localparam int BIT_OSC_EN = 0;
	localparam int BIT_UNIT_SEC = 1;
	// mission_setup fields
	localparam int BIT_LOG_EN = 0;
	localparam int BIT_FMT_WIDE = 2;
	localparam int BIT_ROLLOVER = 4;
	localparam int BIT_START_ALARM = 5;
	localparam logic [7:0] SETUP_STORED_MASK = 8'h3D;
	localparam logic [7:0] SETUP_FIXED_ONES = 8'hC0;
	// alarm_flags fields
	localparam int BIT_LOW_FLAG = 0;
	localparam int BIT_HIGH_FLAG = 1;
	localparam int BIT_BATT_RESET = 7;
	localparam logic [7:0] FLAGS_FIXED_ONES = 8'h70;
	// mission_state fields
	localparam int BIT_RUNNING = 1;
	localparam int BIT_MEM_CLEARED = 3;
	localparam int BIT_WAIT_ALARM = 4;
	localparam logic [7:0] STATE_FIXED_ONES = 8'hC0;

	// log memory layout
	localparam logic [LOG_ADDR_W-1:0] LOG_BASE = 16'h1000;
	localparam int LOG_BYTES = 8192;

	typedef enum logic [1:0] {
		LMAC_IDLE = 2'b00,
		LMAC_WAIT_ALARM = 2'b01,
		LMAC_LOGGING = 2'b11,
		LMAC_LOG_FULL = 2'b10
	} lmac_state_type;
endpackage

// ===== rtl/lmac_regs.sv
/*
 * Mission and alarm control register bank of a temperature logger:
 * thresholds, alarm enables, clock control, mission setup, sticky alarm
 * flags, mission status and the log write pointer.
 * Assumes command strobes and conversion results arrive one-cycle wide
 * from logic on sys_clk; the log memory writer follows log_addr_q.
 */
// The Avalon-MM slave port was left to the implementer.
// Overview of operation
// [RL1] high flag when result at or above threshold
// [RL2] low flag when result at or below threshold
// [RL3] enables in bits 1,0; rest read 0
// [RL4] configuration writable only between missions
// [RL5] unit bit: 0 minutes, 1 seconds
// [RL6] oscillator enable bit runs or stops oscillator
// [RL7] forced conversion or start sets oscillator enable
// [RL8] setup bits 7,6 always read 1
// [RL9] host writes setup bit 1 as 0
// [RL10] start-on-alarm: 8-bit conversions until alarm
// [RL11] first alarming sample logged, not counted
// [RL12] rollover on: wrap to log start
// [RL13] rollover off: stop when full, stay running
// [RL14] format bit: 8/16-bit records, MSB first
// [RL15] logging enable; records start at log base
// [RL16] flag register read-only with fixed bits
// [RL17] clear memory clears all alarm flags
// [RL18] battery reset flag set after power-on
// [RL19] alarm flags sticky; forced conversion updates them
// [RL20] status register read-only with fixed bits
// [RL21] alarm pending answers conditional search
// [RL22] compare on result MSB only
// [RL23] waiting flag cleared by alarm, not clear memory
// [RL24] memory-cleared set by clear, dropped on start
// [RL25] running bit tracks the mission
// [RL26] comparisons are unsigned 8-bit
`timescale 1ns/1ps
module lmac_regs #(
	parameter int LOG_SIZE = lmac_pkg::LOG_BYTES
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// avalon-mm slave
	input wire logic [lmac_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [lmac_pkg::DATA_W-1:0] avs_writedata,
	output logic [lmac_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	// command strobes
	input wire logic clear_memory_cmd,
	input wire logic start_mission_cmd,
	input wire logic stop_mission_cmd,
	input wire logic forced_conv_cmd,
	// conversion result
	input wire logic conv_valid,
	input wire logic conv_forced,
	input wire logic [7:0] conv_msb,
	// controls to the rest of the logger
	output logic oscillator_enable,
	output logic sample_unit_seconds,
	output logic conversions_enable,
	output logic conv_8bit_only,
	output logic log_format_wide,
	output logic [lmac_pkg::LOG_ADDR_W-1:0] log_addr,
	output logic log_store,
	output logic sample_count_inc,
	output logic alarm_pending
);
	import lmac_pkg::*;

	localparam logic [LOG_ADDR_W-1:0] LOG_LAST = LOG_ADDR_W'(LOG_BASE + LOG_SIZE - 1);

	logic [7:0] low_thr_q;
	logic [7:0] high_thr_q;
	logic high_en_q;
	logic low_en_q;
	logic osc_en_q;
	logic unit_sec_q;
	logic [7:0] setup_q;
	logic high_flag_q;
	logic low_flag_q;
	logic batt_reset_q;
	logic mem_cleared_q;
	logic wait_alarm_q;
	lmac_state_type state_q;
	lmac_state_type state_d;
	logic waitreq_q;
	logic [DATA_W-1:0] rdata_q;
	logic [LOG_ADDR_W-1:0] log_addr_q;
	logic log_store_q;
	logic count_inc_q;
	logic conv_en_q;
	logic conv8_q;
	logic pending_q;

	logic [9:0] idx;
	logic wr_go;
	logic cfg_wr;
	logic high_hit;
	logic low_hit;
	logic any_hit;
	logic running;
	logic judged;
	logic take_sample;
	logic [LOG_ADDR_W-1:0] step;
	logic [LOG_ADDR_W-1:0] next_addr;
	logic at_end;
	logic [7:0] flags_rd;
	logic [7:0] state_rd;

	assign idx = avs_address[ADDR_W-1:2];
	// write lands at the edge where the master sees waitrequest low
	assign wr_go = avs_write && !waitreq_q;
	assign cfg_wr = wr_go && (state_q == LMAC_IDLE); // RL4
	assign running = (state_q != LMAC_IDLE); // RL25

	// alarm compare: MSB only, unsigned
	assign high_hit = high_en_q && (conv_msb >= high_thr_q); // RL1 RL22 RL26
	assign low_hit = low_en_q && (conv_msb <= low_thr_q); // RL2 RL22 RL26
	assign any_hit = high_hit || low_hit;
	// forced conversions count between missions too
	assign judged = conv_valid && (running || conv_forced); // RL19

	assign take_sample = conv_valid && !conv_forced && setup_q[BIT_LOG_EN] &&
		((state_q == LMAC_LOGGING) || (state_q == LMAC_WAIT_ALARM && any_hit)); // RL15
	assign step = setup_q[BIT_FMT_WIDE] ? LOG_ADDR_W'(2) : LOG_ADDR_W'(1); // RL14
	assign next_addr = log_addr_q + step;
	assign at_end = (next_addr > LOG_LAST) || (next_addr < LOG_BASE);

	assign flags_rd = {batt_reset_q, FLAGS_FIXED_ONES[6:4], 2'b00, high_flag_q, low_flag_q}; // RL16
	assign state_rd = {STATE_FIXED_ONES[7:6], 1'b0, wait_alarm_q, mem_cleared_q,
		1'b0, running, 1'b0}; // RL20

	// bus handshake: one wait state, then a single-cycle answer
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			waitreq_q <= 1'b1;
		end else begin
			waitreq_q <= !((avs_read || avs_write) && waitreq_q);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= '0;
		end else if (avs_read && waitreq_q) begin
			unique case (idx)
				IDX_LOW_THR: rdata_q <= {24'h00_0000, low_thr_q};
				IDX_HIGH_THR: rdata_q <= {24'h00_0000, high_thr_q};
				IDX_SENSOR_EN: rdata_q <= {30'h0000_0000, high_en_q, low_en_q}; // RL3
				IDX_CLOCK_CTRL: rdata_q <= {30'h0000_0000, unit_sec_q, osc_en_q};
				IDX_MISSION_SETUP: rdata_q <= {24'h00_0000, setup_q}; // RL8
				IDX_ALARM_FLAGS: rdata_q <= {24'h00_0000, flags_rd};
				IDX_MISSION_STATE: rdata_q <= {24'h00_0000, state_rd};
				default: rdata_q <= '0;
			endcase
		end
	end

	// configuration registers, locked during a mission
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			low_thr_q <= 8'h00;
			high_thr_q <= 8'hFF;
			low_en_q <= 1'b0;
			high_en_q <= 1'b0;
			unit_sec_q <= 1'b0;
			setup_q <= SETUP_FIXED_ONES;
		end else if (cfg_wr) begin
			if (idx == IDX_LOW_THR) begin
				low_thr_q <= avs_writedata[7:0];
			end
			if (idx == IDX_HIGH_THR) begin
				high_thr_q <= avs_writedata[7:0];
			end
			if (idx == IDX_SENSOR_EN) begin
				low_en_q <= avs_writedata[BIT_LOW_EN]; // RL3
				high_en_q <= avs_writedata[BIT_HIGH_EN]; // RL3
			end
			if (idx == IDX_CLOCK_CTRL) begin
				unit_sec_q <= avs_writedata[BIT_UNIT_SEC]; // RL5
			end
			if (idx == IDX_MISSION_SETUP) begin
				// bit 1 kept at 0 so bit 3 stays inert
				setup_q <= (avs_writedata[7:0] & SETUP_STORED_MASK & 8'hF5) |
					SETUP_FIXED_ONES; // RL8 RL9
			end
		end
	end

	// oscillator: commands set it, so they win over a clearing write
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_en_q <= 1'b0;
		end else if (forced_conv_cmd || (start_mission_cmd && !running)) begin
			osc_en_q <= 1'b1; // RL7
		end else if (cfg_wr && idx == IDX_CLOCK_CTRL) begin
			osc_en_q <= avs_writedata[BIT_OSC_EN]; // RL6
		end
	end

	// mission sequencing
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			LMAC_IDLE: begin
				if (start_mission_cmd && mem_cleared_q) begin
					state_d = setup_q[BIT_START_ALARM] ? LMAC_WAIT_ALARM : LMAC_LOGGING; // RL10
				end
			end
			LMAC_WAIT_ALARM: begin
				if (stop_mission_cmd) begin
					state_d = LMAC_IDLE;
				end else if (conv_valid && !conv_forced && any_hit) begin
					state_d = LMAC_LOGGING; // RL10
				end
			end
			LMAC_LOGGING: begin
				if (stop_mission_cmd) begin
					state_d = LMAC_IDLE;
				end else if (take_sample && at_end && !setup_q[BIT_ROLLOVER]) begin
					state_d = LMAC_LOG_FULL; // RL13
				end
			end
			LMAC_LOG_FULL: begin
				if (stop_mission_cmd) begin
					state_d = LMAC_IDLE; // RL13
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= LMAC_IDLE;
		end else begin
			state_q <= state_d; // RL25
		end
	end

	// log write pointer and per-sample strobes
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			log_addr_q <= LOG_BASE;
			log_store_q <= 1'b0;
			count_inc_q <= 1'b0;
		end else begin
			log_store_q <= take_sample;
			// the alarm that opens a start-on-alarm mission is not counted
			count_inc_q <= take_sample && (state_q == LMAC_LOGGING); // RL11
			if (state_q == LMAC_IDLE) begin
				log_addr_q <= LOG_BASE; // RL15
			end else if (log_store_q && state_q != LMAC_IDLE) begin
				log_addr_q <= at_end ? LOG_BASE : next_addr; // RL12 RL14
			end
		end
	end

	// sticky alarm flags; a new hit beats a clear in the same cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			high_flag_q <= 1'b0;
			low_flag_q <= 1'b0;
			batt_reset_q <= 1'b1; // RL18
		end else begin
			if (judged && high_hit) begin
				high_flag_q <= 1'b1; // RL1 RL19
			end else if (clear_memory_cmd) begin
				high_flag_q <= 1'b0; // RL17
			end
			if (judged && low_hit) begin
				low_flag_q <= 1'b1; // RL2 RL19
			end else if (clear_memory_cmd) begin
				low_flag_q <= 1'b0; // RL17
			end
			if (clear_memory_cmd) begin
				batt_reset_q <= 1'b0; // RL17
			end
		end
	end

	// status bits
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_cleared_q <= 1'b0;
			wait_alarm_q <= 1'b0;
		end else begin
			if (state_q == LMAC_IDLE && state_d != LMAC_IDLE) begin
				mem_cleared_q <= 1'b0; // RL24
			end else if (clear_memory_cmd && state_q == LMAC_IDLE) begin
				mem_cleared_q <= 1'b1; // RL24
			end
			// survives a stop; only an alarm event removes it
			if (judged && any_hit) begin
				wait_alarm_q <= 1'b0; // RL23
			end else if (state_q == LMAC_IDLE && state_d == LMAC_WAIT_ALARM) begin
				wait_alarm_q <= 1'b1;
			end
		end
	end

	// registered outputs
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			conv_en_q <= 1'b0;
			conv8_q <= 1'b0;
			pending_q <= 1'b0;
		end else begin
			conv_en_q <= (state_d == LMAC_WAIT_ALARM) || (state_d == LMAC_LOGGING); // RL13
			conv8_q <= (state_d == LMAC_WAIT_ALARM); // RL10
			pending_q <= high_flag_q || low_flag_q || batt_reset_q; // RL21
		end
	end

	assign avs_waitrequest = waitreq_q;
	assign avs_readdata = rdata_q;
	assign oscillator_enable = osc_en_q;
	assign sample_unit_seconds = unit_sec_q;
	assign conversions_enable = conv_en_q;
	assign conv_8bit_only = conv8_q;
	assign log_format_wide = setup_q[BIT_FMT_WIDE];
	assign log_addr = log_addr_q;
	assign log_store = log_store_q;
	assign sample_count_inc = count_inc_q;
	assign alarm_pending = pending_q;

	sequence bus_req_s;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence bus_ack_s;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence

	bus_answer_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // bus handshake
		bus_req_s |=> bus_ack_s) else $error("bus answer not one wait state");
	cfg_lock_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL4
		running |=> $stable(low_thr_q) && $stable(high_thr_q) && $stable(setup_q))
		else $error("config changed during mission");
	high_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL1
		conv_valid && running && high_en_q && conv_msb >= high_thr_q |=> high_flag_q)
		else $error("high alarm not flagged");
	low_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL2
		conv_valid && running && low_en_q && conv_msb <= low_thr_q |=> low_flag_q)
		else $error("low alarm not flagged");
	setup_ones_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL8
		setup_q[7:6] == 2'b11) else $error("setup fixed bits lost");
	osc_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL7
		forced_conv_cmd |=> oscillator_enable) else $error("oscillator not started");
	flag_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL17
		clear_memory_cmd && !conv_valid ##1 !conv_valid |->
		!batt_reset_q && !high_flag_q && !low_flag_q ##1 !alarm_pending)
		else $error("flags not cleared");
	first_uncounted_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL11
		state_q == LMAC_WAIT_ALARM && take_sample |=> log_store && !sample_count_inc)
		else $error("first alarm sample counted");
	full_stop_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL13
		state_q == LMAC_LOG_FULL && !stop_mission_cmd |=>
		running && !conversions_enable && !log_store)
		else $error("full mission lost running state");
	mem_clear_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL24
		state_q == LMAC_IDLE && state_d != LMAC_IDLE |=> !mem_cleared_q && running)
		else $error("memory-cleared kept at start");
	wait_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL23
		judged && any_hit |=> !wait_alarm_q) else $error("waiting bit not cleared");
endmodule

// ===== verif/lmac_host_model.sv
/*
 * Host-side model: the avalon-mm master that reaches the register bank.
 * Assumes the bank shares sys_clk; the bench calls access() for each bus transfer.
 */
`timescale 1ns/1ps
module lmac_host_model (
	// clock
	input wire logic sys_clk,
	// avalon-mm master
	input wire logic avs_waitrequest,
	input wire logic [lmac_pkg::DATA_W-1:0] avs_readdata,
	output logic [lmac_pkg::ADDR_W-1:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [lmac_pkg::DATA_W-1:0] avs_writedata
);
	import lmac_pkg::*;
	initial begin
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
	end
	// request held until waitrequest seen low; no latency assumed
	task automatic access(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
		output logic [DATA_W-1:0] rd);
		@(posedge sys_clk);
		avs_address <= {idx, 2'b00};
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {24'h00_0000, wd};
		// answer and read data are taken only at a rising edge
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
endmodule

// ===== verif/test_logger_mission_alarm_control.sv
/*
 * Self-checking bench of the mission/alarm register bank.
 * Assumes the host model drives the bus; commands and conversions come from here.
 */
`timescale 1ns/1ps
module test_logger_mission_alarm_control;
	import lmac_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] cmd_v = 4'h0;
	logic conv_valid = 1'b0;
	logic conv_forced = 1'b0;
	logic [7:0] conv_msb = 8'h00;
	logic [ADDR_W-1:0] avs_address;
	logic avs_read, avs_write, avs_waitrequest;
	logic [DATA_W-1:0] avs_writedata, avs_readdata, rd;
	logic osc, unit, conv_en, only8, wide, store, inc, pend;
	logic [LOG_ADDR_W-1:0] log_addr;
	logic st_seen, inc_seen;
	logic [LOG_ADDR_W-1:0] addr_at;
	int n_fail = 0;
	int cmp_count = 0;
	// small log so the full condition is reached in a few samples
	localparam int LSZ = 8;

	initial begin
		forever #20 sys_clk = ~sys_clk;
	end

	lmac_regs #(.LOG_SIZE(LSZ)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .clear_memory_cmd(cmd_v[0]),
		.start_mission_cmd(cmd_v[1]), .stop_mission_cmd(cmd_v[2]),
		.forced_conv_cmd(cmd_v[3]), .conv_valid(conv_valid), .conv_forced(conv_forced),
		.conv_msb(conv_msb), .oscillator_enable(osc), .sample_unit_seconds(unit),
		.conversions_enable(conv_en), .conv_8bit_only(only8), .log_format_wide(wide),
		.log_addr(log_addr), .log_store(store), .sample_count_inc(inc),
		.alarm_pending(pend));

	lmac_host_model host_u (.sys_clk(sys_clk), .avs_waitrequest(avs_waitrequest),
		.avs_readdata(avs_readdata), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata));

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		host_u.access(1'b1, idx, d, rd);
		// write lands at this edge; let the registers settle before any check
		#1;
	endtask

	task automatic rd_chk(input string nm, input logic [9:0] idx, input logic [7:0] e);
		host_u.access(1'b0, idx, 8'h00, rd);
		check(nm, rd, {24'h00_0000, e});
	endtask

	// one-cycle command strobe; outputs settle one edge after it is taken
	task automatic cmd(input logic [3:0] m);
		@(posedge sys_clk);
		cmd_v <= m;
		@(posedge sys_clk);
		cmd_v <= 4'h0;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask

	task automatic conv(input logic [7:0] msb);
		@(posedge sys_clk);
		conv_valid <= 1'b1;
		conv_msb <= msb;
		@(posedge sys_clk);
		conv_valid <= 1'b0;
		#1;
		st_seen = store;
		inc_seen = inc;
		addr_at = log_addr;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask

	task automatic t_reset;
		rd_chk("low thr", IDX_LOW_THR, 8'h00);
		rd_chk("high thr", IDX_HIGH_THR, 8'hFF);
		rd_chk("setup", IDX_MISSION_SETUP, 8'hC0);
		rd_chk("flags", IDX_ALARM_FLAGS, 8'hF0);
		rd_chk("state", IDX_MISSION_STATE, 8'hC0);
		check("pending", pend, 1'b1);
		$display("test reset done");
	endtask

	task automatic t_config;
		wr(IDX_SENSOR_EN, 8'hFF);
		rd_chk("enables", IDX_SENSOR_EN, 8'h03);
		wr(IDX_CLOCK_CTRL, 8'hFF);
		rd_chk("clock ctrl", IDX_CLOCK_CTRL, 8'h03);
		check("unit sec", {unit, osc}, 2'b11);
		wr(IDX_CLOCK_CTRL, 8'h00);
		check("unit min", {unit, osc}, 2'b00);
		cmd(4'h8);
		check("osc forced", osc, 1'b1);
		// forced result between missions: judged against 0xFF, never logged
		@(posedge sys_clk);
		conv_forced <= 1'b1;
		conv(8'hFF);
		@(posedge sys_clk);
		conv_forced <= 1'b0;
		check("forced no log", st_seen, 1'b0);
		wr(IDX_MISSION_SETUP, 8'h00);
		rd_chk("setup ones", IDX_MISSION_SETUP, 8'hC0);
		wr(IDX_ALARM_FLAGS, 8'h00);
		rd_chk("flags ro", IDX_ALARM_FLAGS, 8'hF2);
		rd_chk("unmapped", 10'h211, 8'h00);
		$display("test config done");
	endtask

	task automatic t_mission;
		cmd(4'h1);
		rd_chk("flags clr", IDX_ALARM_FLAGS, 8'h70);
		rd_chk("memory_cleared", IDX_MISSION_STATE, 8'hC8);
		check("pending clr", pend, 1'b0);
		wr(IDX_LOW_THR, 8'h40);
		wr(IDX_HIGH_THR, 8'h80);
		wr(IDX_SENSOR_EN, 8'h03);
		wr(IDX_CLOCK_CTRL, 8'h00);
		wr(IDX_MISSION_SETUP, 8'h01);
		cmd(4'h2);
		check("osc start", osc, 1'b1);
		rd_chk("running", IDX_MISSION_STATE, 8'hC2);
		wr(IDX_HIGH_THR, 8'h10);
		rd_chk("thr locked", IDX_HIGH_THR, 8'h80);
		conv(8'h80);
		check("first addr", {st_seen, addr_at}, {1'b1, 16'h1000});
		check("next addr", log_addr, 16'h1001);
		rd_chk("high hit", IDX_ALARM_FLAGS, 8'h72);
		check("pending hit", pend, 1'b1);
		conv(8'h41);
		rd_chk("no low", IDX_ALARM_FLAGS, 8'h72);
		conv(8'h40);
		rd_chk("low hit", IDX_ALARM_FLAGS, 8'h73);
		repeat (LSZ - 3) conv(8'h50);
		check("full stop", conv_en, 1'b0);
		conv(8'h50);
		check("no store full", st_seen, 1'b0);
		rd_chk("still run", IDX_MISSION_STATE, 8'hC2);
		cmd(4'h4);
		rd_chk("stopped", IDX_MISSION_STATE, 8'hC0);
		$display("test mission done");
	endtask

	task automatic t_start_alarm;
		cmd(4'h1);
		wr(IDX_SENSOR_EN, 8'h02);
		wr(IDX_MISSION_SETUP, 8'h25);
		cmd(4'h2);
		rd_chk("waiting", IDX_MISSION_STATE, 8'hD2);
		check("mode", {only8, wide}, 2'b11);
		conv(8'h10);
		check("no log", st_seen, 1'b0);
		conv(8'h90);
		check("alarm log", {st_seen, inc_seen}, 2'b10);
		rd_chk("wait gone", IDX_MISSION_STATE, 8'hC2);
		conv(8'h90);
		check("wide step", {st_seen, inc_seen, addr_at}, {2'b11, 16'h1002});
		cmd(4'h4);
		$display("test start on alarm done");
	endtask

	task automatic t_rollover;
		cmd(4'h1);
		wr(IDX_MISSION_SETUP, 8'h11);
		cmd(4'h2);
		// one sample more than the log holds: the last one lands at the base
		repeat (LSZ + 1) conv(8'h50);
		check("wrap", {st_seen, inc_seen, addr_at}, {2'b11, 16'h1000});
		check("wrap run", conv_en, 1'b1);
		cmd(4'h4);
		$display("test rollover done");
	endtask

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		#200000;
		n_fail++;
		summarize();
	end

	initial begin
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset();
		t_config();
		t_mission();
		t_start_alarm();
		t_rollover();
		summarize();
	end
endmodule
